// file: usc_serial_ctrl.sv
// Purpose: Control logic of a serial shift unit with 8-bit shifter and 4-bit counter.
// Assumes: Avalon-MM slave with waitrequest; start detector and timer are outside.
// Notes: Pins are split into input, output and output enable; pads resolve the wire.
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`default_nettype none
`include "usc_map.svh"
module usc_serial_ctrl
  import usc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        global_irq_enable,
  output logic             overflow_irq_request,
  input  wire logic        timer_compare_match,
  input  wire logic        start_detected,
  input  wire logic        serial_data_in_i,
  output logic             serial_data_in_o,
  output logic             serial_data_in_oe,
  output logic             serial_data_in_pullup,
  input  wire logic        serial_clock_pin_i,
  output logic             serial_clock_pin_o,
  output logic             serial_clock_pin_oe,
  output logic             serial_clock_pin_pullup,
  output logic             data_out_o,
  output logic             data_out_oe,
  output logic             data_out_pullup
);
  usc_edge_if data_edge ();
  usc_edge_if clock_edge ();

  usc_pin_sync data_sync (
    .clk    (clk),
    .rst    (rst),
    .pin_i  (serial_data_in_i),
    .edge_o (data_edge)
  );

  usc_pin_sync clock_sync (
    .clk    (clk),
    .rst    (rst),
    .pin_i  (serial_clock_pin_i),
    .edge_o (clock_edge)
  );

  logic                   served_reg;
  logic                   served_next;
  logic [31:0]            rdata_reg;
  logic [31:0]            rdata_next;
  logic                   ovf_ie_reg;
  logic                   ovf_ie_next;
  usc_wire_mode_e         wm_reg;
  usc_wire_mode_e         wm_next;
  usc_clock_src_e         cs_reg;
  usc_clock_src_e         cs_next;
  logic                   clk_sel_reg;
  logic                   clk_sel_next;
  logic [`USC_PIN_HI:0]   pins_reg;
  logic [`USC_PIN_HI:0]   pins_next;
  logic [7:0]             shift_reg;
  logic [7:0]             shift_next;
  logic [7:0]             buffer_reg;
  logic [7:0]             buffer_next;
  logic [3:0]             cnt_reg;
  logic [3:0]             cnt_next;
  logic                   ovf_flag_reg;
  logic                   ovf_flag_next;
  logic                   start_flag_reg;
  logic                   start_flag_next;
  logic                   latch_reg;
  logic                   latch_next;
  logic                   di_prev_reg;
  logic                   di_prev_next;

  logic                   wr_go;
  logic                   rd_go;
  logic                   wr_ctl;
  logic                   wr_sta;
  logic                   wr_dat;
  logic                   wr_pin;
  logic                   rd_buf;
  logic                   soft_strobe;
  logic                   toggle_strobe;
  logic                   ext_shift_edge;
  logic                   ext_other_edge;
  logic                   ext_any_edge;
  logic                   shift_tick;
  logic                   cnt_tick;
  logic                   shift_in;
  logic                   data_msb;
  logic                   two_wire;
  logic                   clk_hold;
  logic [7:0]             ctl_read;
  logic [7:0]             sta_read;

  // The slave answers every access in its second cycle; the first registers read data.
  assign avs_waitrequest = (avs_read | avs_write) & ~served_reg;
  assign wr_go  = avs_write & served_reg & avs_byteenable[0];
  assign rd_go  = avs_read & served_reg;
  assign wr_ctl = wr_go & (avs_address == `USC_ADDR_CONTROL);
  assign wr_sta = wr_go & (avs_address == `USC_ADDR_STATUS);
  assign wr_dat = wr_go & (avs_address == `USC_ADDR_DATA);
  assign wr_pin = wr_go & (avs_address == `USC_ADDR_PINS);
  assign rd_buf = rd_go & (avs_address == `USC_ADDR_BUFFER);
  assign avs_readdata = rdata_reg;

  assign soft_strobe   = wr_ctl & avs_writedata[`USC_CTL_STROBE];
  assign toggle_strobe = wr_ctl & avs_writedata[`USC_CTL_TOGGLE];

  // Edges come from the synchronised pin whatever the wire mode.
  assign ext_shift_edge = cs_reg[0] ? clock_edge.fall : clock_edge.rise;
  assign ext_other_edge = cs_reg[0] ? clock_edge.rise : clock_edge.fall;
  assign ext_any_edge   = clock_edge.rise | clock_edge.fall;

  always_comb begin
    shift_tick = 1'b0;
    cnt_tick   = 1'b0;
    shift_in   = data_edge.level;
    unique case (cs_reg)
      usc_cs_soft: begin
        shift_tick = soft_strobe;
        cnt_tick   = soft_strobe;
        shift_in   = di_prev_reg;
      end
      usc_cs_timer: begin
        shift_tick = timer_compare_match;
        cnt_tick   = timer_compare_match;
      end
      usc_cs_ext_pos, usc_cs_ext_neg: begin
        shift_tick = ext_shift_edge;
        cnt_tick   = clk_sel_reg ? toggle_strobe : ext_any_edge;
      end
    endcase
  end

  // Internal clocks see the shifter MSB directly; external clocks go through the latch.
  assign data_msb = cs_reg[1] ? latch_reg : shift_reg[7];
  assign two_wire = wm_reg[1];
  // Holds exist only in two-wire modes, so mode zero never stretches the clock.
  assign clk_hold = two_wire & (start_flag_reg
                  | ((wm_reg == usc_wm_two_hold) & ovf_flag_reg));

  always_comb begin
    ctl_read = `USC_RESET_BYTE;
    ctl_read[`USC_CTL_OVF_IE] = ovf_ie_reg;
    ctl_read[`USC_CTL_WM_HI:`USC_CTL_WM_LO] = wm_reg;
    ctl_read[`USC_CTL_CS_HI:`USC_CTL_CS_LO] = cs_reg;
    sta_read = `USC_RESET_BYTE;
    sta_read[`USC_STA_START] = start_flag_reg;
    sta_read[`USC_STA_OVF] = ovf_flag_reg;
    sta_read[`USC_STA_CNT_HI:0] = cnt_reg;
  end

  always_comb begin
    served_next = (avs_read | avs_write) & ~served_reg;
    rdata_next  = rdata_reg;
    if (avs_read & ~served_reg) begin
      unique case (avs_address)
        `USC_ADDR_CONTROL: rdata_next = {24'h000000, ctl_read};
        `USC_ADDR_STATUS:  rdata_next = {24'h000000, sta_read};
        `USC_ADDR_DATA:    rdata_next = {24'h000000, shift_reg};
        `USC_ADDR_BUFFER:  rdata_next = {24'h000000, buffer_reg};
        `USC_ADDR_PINS:    rdata_next = {26'h0000000, pins_reg};
        default:           rdata_next = 32'h00000000;
      endcase
    end
  end

  always_comb begin
    ovf_ie_next     = ovf_ie_reg;
    wm_next         = wm_reg;
    cs_next         = cs_reg;
    clk_sel_next    = clk_sel_reg;
    pins_next       = pins_reg;
    shift_next      = shift_reg;
    buffer_next     = buffer_reg;
    cnt_next        = cnt_reg;
    ovf_flag_next   = ovf_flag_reg;
    start_flag_next = start_flag_reg;
    latch_next      = latch_reg;
    di_prev_next    = data_edge.level;
    if (wr_ctl) begin
      ovf_ie_next  = avs_writedata[`USC_CTL_OVF_IE];
      wm_next      = usc_wire_mode_e'(avs_writedata[`USC_CTL_WM_HI:`USC_CTL_WM_LO]);
      cs_next      = usc_clock_src_e'(avs_writedata[`USC_CTL_CS_HI:`USC_CTL_CS_LO]);
      clk_sel_next = avs_writedata[`USC_CTL_STROBE];
    end
    if (wr_pin) begin
      pins_next = avs_writedata[`USC_PIN_HI:0];
    end
    if (toggle_strobe) begin
      pins_next[`USC_PIN_CLK_PORT] = ~pins_reg[`USC_PIN_CLK_PORT];
    end
    // A write to the data register wins over a shift in the same cycle.
    if (wr_dat) begin
      shift_next = avs_writedata[7:0];
    end else if (shift_tick) begin
      shift_next = {shift_reg[6:0], shift_in};
    end
    if (cs_reg[1]) begin
      if (ext_other_edge) begin
        latch_next = shift_reg[7];
      end
    end else begin
      latch_next = shift_next[7];
    end
    if (wr_sta & avs_writedata[`USC_STA_OVF]) begin
      ovf_flag_next = 1'b0;
    end
    if (rd_buf) begin
      ovf_flag_next = 1'b0;
    end
    if (wr_sta) begin
      cnt_next = avs_writedata[`USC_STA_CNT_HI:0];
    end else if (cnt_tick) begin
      cnt_next = cnt_reg + 4'h1;
      if (cnt_reg == `USC_CNT_MAX) begin
        ovf_flag_next = 1'b1;
        buffer_next   = shift_next;
      end
    end
    if (wr_sta & avs_writedata[`USC_STA_START]) begin
      start_flag_next = 1'b0;
    end
    // The set is placed last so an event never loses to a clear in the same cycle.
    if (two_wire & start_detected) begin
      start_flag_next = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      served_reg     <= 1'b0;
      rdata_reg      <= 32'h00000000;
      ovf_ie_reg     <= 1'b0;
      wm_reg         <= usc_wm_off;
      cs_reg         <= usc_cs_soft;
      clk_sel_reg    <= 1'b0;
      pins_reg       <= `USC_RESET_PINS;
      shift_reg      <= `USC_RESET_BYTE;
      buffer_reg     <= `USC_RESET_BYTE;
      cnt_reg        <= 4'h0;
      ovf_flag_reg   <= 1'b0;
      start_flag_reg <= 1'b0;
      latch_reg      <= 1'b0;
      di_prev_reg    <= 1'b0;
    end else begin
      served_reg     <= served_next;
      rdata_reg      <= rdata_next;
      ovf_ie_reg     <= ovf_ie_next;
      wm_reg         <= wm_next;
      cs_reg         <= cs_next;
      clk_sel_reg    <= clk_sel_next;
      pins_reg       <= pins_next;
      shift_reg      <= shift_next;
      buffer_reg     <= buffer_next;
      cnt_reg        <= cnt_next;
      ovf_flag_reg   <= ovf_flag_next;
      start_flag_reg <= start_flag_next;
      latch_reg      <= latch_next;
      di_prev_reg    <= di_prev_next;
    end
  end

  // Level request; a flag already pending appears as soon as both enables are one.
  assign overflow_irq_request = ovf_flag_reg & ovf_ie_reg & global_irq_enable;

  always_comb begin
    serial_data_in_o        = pins_reg[`USC_PIN_DAT_PORT];
    serial_data_in_oe       = pins_reg[`USC_PIN_DAT_DIR];
    serial_data_in_pullup   = ~pins_reg[`USC_PIN_DAT_DIR] & pins_reg[`USC_PIN_DAT_PORT];
    serial_clock_pin_o      = pins_reg[`USC_PIN_CLK_PORT];
    serial_clock_pin_oe     = pins_reg[`USC_PIN_CLK_DIR];
    serial_clock_pin_pullup = ~pins_reg[`USC_PIN_CLK_DIR] & pins_reg[`USC_PIN_CLK_PORT];
    data_out_o              = pins_reg[`USC_PIN_DO_PORT];
    data_out_oe             = pins_reg[`USC_PIN_DO_DIR];
    data_out_pullup         = ~pins_reg[`USC_PIN_DO_DIR] & pins_reg[`USC_PIN_DO_PORT];
    unique case (wm_reg)
      usc_wm_off: begin
      end
      usc_wm_three: begin
        data_out_o = data_msb;
      end
      usc_wm_two, usc_wm_two_hold: begin
        // Open drain: the pad only ever sinks, so the level driven is always zero.
        serial_data_in_o        = 1'b0;
        serial_data_in_oe       = pins_reg[`USC_PIN_DAT_DIR]
                                & (~data_msb | ~pins_reg[`USC_PIN_DAT_PORT]);
        serial_data_in_pullup   = 1'b0;
        serial_clock_pin_o      = 1'b0;
        serial_clock_pin_oe     = pins_reg[`USC_PIN_CLK_DIR]
                                & (~pins_reg[`USC_PIN_CLK_PORT] | clk_hold);
        serial_clock_pin_pullup = 1'b0;
      end
    endcase
  end
endmodule : usc_serial_ctrl
`default_nettype wire

// file: usc_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the serial shift control.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, one register per aligned word.
// Notes: Included by its bare name; holds definitions only.
// Contract
// - Overflow enable plus global enable lets a set overflow flag request an interrupt.
// - A pending overflow flag raises the request at once when both enables become one.
// - Wire mode alters outputs only; inputs still clock and feed the shifter; start flag setting is also gated on two-wire modes.
// - Wire mode zero disables outputs, clock holds and start detection; pins follow port bits.
// - Three-wire mode puts shifter output on the data pin; direction and pull-up unchanged.
// - Two-wire data driver pulls low when shifter MSB or port bit is zero.
// - Two-wire clock driver pulls low when port bit is zero or a hold is demanded.
// - After a start condition the clock stays low until software clears the start flag.
// - Two-wire modes disable both pull-ups; input paths stay as they are.
// - Wire mode three also holds clock low from overflow until the flag clears.
// - External clock changes output on the opposite edge; internal clocks keep latch transparent.
// - Clock source zero applies no clock unless strobe written one, which clocks both.
// - Software strobe shifts and counts at once, shifting in last cycle's sample.
// - Clock source one clocks shifter and counter on timer compare match.
// - External source picks shift edge by low bit; counter counts both edges.
// - External source with strobe bit set counts toggle strobe writes instead.
// - Toggle strobe inverts the clock port bit whatever its direction bit says.
// - Strobe and toggle strobe bits always read as zero.
// - Overflow flag sets on counter wrap to zero; cleared by write one or buffer read.
// - Two-wire start flag sets on a detected start; only a written one clears it.
`ifndef USC_MAP_SVH
`define USC_MAP_SVH
`define USC_ADDR_CONTROL   8'h00
`define USC_ADDR_STATUS    8'h04
`define USC_ADDR_DATA      8'h08
`define USC_ADDR_BUFFER    8'h0c
`define USC_ADDR_PINS      8'h10
`define USC_CTL_OVF_IE     6
`define USC_CTL_WM_HI      5
`define USC_CTL_WM_LO      4
`define USC_CTL_CS_HI      3
`define USC_CTL_CS_LO      2
`define USC_CTL_STROBE     1
`define USC_CTL_TOGGLE     0
`define USC_STA_START      7
`define USC_STA_OVF        6
`define USC_STA_CNT_HI     3
`define USC_PIN_CLK_PORT   0
`define USC_PIN_CLK_DIR    1
`define USC_PIN_DAT_PORT   2
`define USC_PIN_DAT_DIR    3
`define USC_PIN_DO_PORT    4
`define USC_PIN_DO_DIR     5
`define USC_PIN_HI         5
`define USC_CNT_MAX        4'hf
`define USC_RESET_BYTE     8'h00
`define USC_RESET_PINS     6'h00
`define USC_SYNC_STAGES    2
`endif

// file: usc_pkg.sv
// Purpose: Types shared by the serial shift control modules.
// Assumes: Encodings follow the two-bit wire mode and clock source fields.
// Notes: Constants live in usc_map.svh.
`default_nettype none
package usc_pkg;
  typedef enum logic [1:0] {
    usc_wm_off,
    usc_wm_three,
    usc_wm_two,
    usc_wm_two_hold
  } usc_wire_mode_e;
  typedef enum logic [1:0] {
    usc_cs_soft,
    usc_cs_timer,
    usc_cs_ext_pos,
    usc_cs_ext_neg
  } usc_clock_src_e;
endpackage : usc_pkg
`default_nettype wire

// file: usc_edge_if.sv
// Purpose: Carries a synchronised pin level and its edge pulses.
// Assumes: All signals belong to the system clock domain.
// Notes: One instance per sampled pin.
`default_nettype none
interface usc_edge_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : usc_edge_if
`default_nettype wire

// file: usc_pin_sync.sv
// Purpose: Two-stage synchroniser with edge detection for one pin.
// Assumes: The pin is asynchronous to clk.
// Notes: Edges are reported in the same cycle as the synchronised level changes.
`default_nettype none
`include "usc_map.svh"
module usc_pin_sync
  import usc_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  input  wire logic  pin_i,
  usc_edge_if.src    edge_o
);
  logic [`USC_SYNC_STAGES-1:0] sync_reg;
  logic [`USC_SYNC_STAGES-1:0] sync_next;
  logic                        last_reg;
  logic                        last_next;

  always_comb begin
    sync_next = {sync_reg[`USC_SYNC_STAGES-2:0], pin_i};
    last_next = sync_reg[`USC_SYNC_STAGES-1];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sync_reg <= '0;
      last_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      last_reg <= last_next;
    end
  end

  // Only the second stage is looked at, so a metastable first stage never leaks.
  assign edge_o.level = sync_reg[`USC_SYNC_STAGES-1];
  assign edge_o.rise  = sync_reg[`USC_SYNC_STAGES-1] & ~last_reg;
  assign edge_o.fall  = ~sync_reg[`USC_SYNC_STAGES-1] & last_reg;
endmodule : usc_pin_sync
`default_nettype wire

// file: usc_serial_ctrl_assertions.sv
// Purpose: Concurrent checks on the ports of the serial shift control.
// Assumes: Control and pin bits are tracked from accepted bus writes.
// Notes: Bound to every instance of usc_serial_ctrl.
`default_nettype none
`include "usc_map.svh"
module usc_serial_ctrl_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        global_irq_enable,
  input wire logic        overflow_irq_request,
  input wire logic        start_detected,
  input wire logic        serial_data_in_o,
  input wire logic        serial_data_in_oe,
  input wire logic        serial_data_in_pullup,
  input wire logic        serial_clock_pin_o,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_clock_pin_pullup,
  input wire logic        data_out_o,
  input wire logic        data_out_oe
);
  logic [7:0] ctl_reg;
  logic [5:0] pins_reg;
  logic       wr_ok;
  logic [1:0] wm;
  assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wm    = ctl_reg[5:4];
  // A toggle write flips the clock port bit, so the shadow must follow it too.
  always_ff @(posedge clk) begin
    if (rst) begin
      ctl_reg  <= `USC_RESET_BYTE;
      pins_reg <= `USC_RESET_PINS;
    end else if (wr_ok && avs_address == `USC_ADDR_CONTROL) begin
      ctl_reg     <= avs_writedata[7:0];
      pins_reg[0] <= pins_reg[0] ^ avs_writedata[0];
    end else if (wr_ok && avs_address == `USC_ADDR_PINS) begin
      pins_reg <= avs_writedata[5:0];
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_irq_cause;
    overflow_irq_request |-> ctl_reg[6] && global_irq_enable;
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without enables");
  property p_port_dir;
    !wm[1] |-> data_out_oe == pins_reg[5] && serial_data_in_oe == pins_reg[3]
      && serial_clock_pin_oe == pins_reg[1];
  endproperty
  a_port_dir: assert property (p_port_dir) else $error("pin enable not from dir");
  property p_off_out;
    wm == 2'b00 |-> data_out_o == pins_reg[4];
  endproperty
  a_off_out: assert property (p_off_out) else $error("data out not port bit");
  property p_pullup_two;
    wm[1] |-> !serial_data_in_pullup && !serial_clock_pin_pullup;
  endproperty
  a_pullup_two: assert property (p_pullup_two) else $error("pull-up on in two-wire");
  property p_sda_od;
    wm[1] && serial_data_in_oe |-> !serial_data_in_o && pins_reg[3];
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("data line driven high");
  property p_scl_od;
    wm[1] && serial_clock_pin_oe |-> !serial_clock_pin_o && pins_reg[1];
  endproperty
  a_scl_od: assert property (p_scl_od) else $error("clock line driven high");
  property p_start_hold;
    wm[1] && start_detected && pins_reg[1] |=> (serial_clock_pin_oe && !serial_clock_pin_o)[*2];
  endproperty
  a_start_hold: assert property (p_start_hold) else $error("no hold after start");
  property p_rd_strobe;
    avs_read && !avs_waitrequest && avs_address == `USC_ADDR_CONTROL |-> avs_readdata[1:0] == 2'b00;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe) else $error("strobe bits read back");
  property p_reset;
    $fell(rst) |-> !overflow_irq_request && !data_out_oe && !serial_clock_pin_oe
      && !serial_data_in_oe;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs active after reset");
  c_start: cover property (wm[1] && start_detected && pins_reg[1]);
  c_irq: cover property (overflow_irq_request);
  c_sda_low: cover property (wm[1] && serial_data_in_oe);
endmodule // usc_serial_ctrl_assertions
bind usc_serial_ctrl usc_serial_ctrl_assertions u_chk (
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .global_irq_enable(global_irq_enable), .overflow_irq_request(overflow_irq_request),
  .start_detected(start_detected), .serial_data_in_o(serial_data_in_o),
  .serial_data_in_oe(serial_data_in_oe), .serial_data_in_pullup(serial_data_in_pullup),
  .serial_clock_pin_o(serial_clock_pin_o), .serial_clock_pin_oe(serial_clock_pin_oe),
  .serial_clock_pin_pullup(serial_clock_pin_pullup), .data_out_o(data_out_o),
  .data_out_oe(data_out_oe)
);
`default_nettype wire

// file: usc_peer_model.sv
// Purpose: Behavioural two-wire master that clocks one byte onto the link.
// Assumes: Both lines have pull-ups; every party may only pull them low.
// Notes: Clock stands high between frames; bit period is 125 ns.
`default_nettype none
module usc_peer_model (
  input  wire logic       go,
  input  wire logic [7:0] tx,
  input  wire logic       ck_o,
  input  wire logic       ck_oe,
  input  wire logic       dat_o,
  input  wire logic       dat_oe,
  output wire logic       scl,
  output wire logic       sda,
  output var  logic       busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  // A released line floats to the pull-up, so only a low drive wins.
  assign scl = scl_drv & ~(ck_oe & ~ck_o);
  assign sda = sda_drv & ~(dat_oe & ~dat_o);
  initial busy = 1'b0;
  always @(posedge go) begin
    busy = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      scl_drv = 1'b0;
      #20 sda_drv = tx[i];
      #42.5 scl_drv = 1'b1;
      #62.5;
    end
    sda_drv = 1'b1;
    busy = 1'b0;
  end
endmodule // usc_peer_model
`default_nettype wire

// file: usc_serial_ctrl_tb_top.sv
// Purpose: Self-checking bench for the serial shift control.
// Assumes: Avalon-MM master tasks; a two-wire peer drives the link lines.
// Notes: Pin outputs are sampled at the falling edge, once registers settle, except the start hold check.
`default_nettype none
`include "usc_map.svh"
module usc_serial_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [7:0]  avs_address = 8'h00, q;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic        avs_waitrequest, irq, busy, gie = 1'b0, tcm = 1'b0, start = 1'b0, go = 1'b0;
  logic        di_o, di_oe, di_pu, ck_o, ck_oe, ck_pu, do_o, do_oe, do_pu;
  wire         sda;
  wire         scl;
  int          fails = 0;
  int          checks_done = 0;
  always #5 clk = ~clk;
  usc_serial_ctrl DUT (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .global_irq_enable(gie),
    .overflow_irq_request(irq), .timer_compare_match(tcm), .start_detected(start),
    .serial_data_in_i(sda), .serial_data_in_o(di_o), .serial_data_in_oe(di_oe),
    .serial_data_in_pullup(di_pu), .serial_clock_pin_i(scl), .serial_clock_pin_o(ck_o),
    .serial_clock_pin_oe(ck_oe), .serial_clock_pin_pullup(ck_pu), .data_out_o(do_o),
    .data_out_oe(do_oe), .data_out_pullup(do_pu));
  usc_peer_model u_peer (.go(go), .tx(8'h96), .ck_o(ck_o), .ck_oe(ck_oe), .dat_o(di_o),
    .dat_oe(di_oe), .scl(scl), .sda(sda), .busy(busy));
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Holds the request until waitrequest is seen low at an edge, then releases it.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) fails++;
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(nm, q, exp);
  endtask
  task automatic pulse_timer();
    @(posedge clk);
    tcm <= 1'b1;
    @(posedge clk);
    tcm <= 1'b0;
  endtask
  task automatic t_soft();
    rdc("pins", `USC_ADDR_PINS, 8'h00);
    bus(1'b1, `USC_ADDR_DATA, 8'ha5);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h00);
    rdc("no clock", `USC_ADDR_DATA, 8'ha5);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h02);
    rdc("shifted", `USC_ADDR_DATA, 8'h4b);
    rdc("count", `USC_ADDR_STATUS, 8'h01);
    rdc("ctl", `USC_ADDR_CONTROL, 8'h00);
  endtask
  task automatic t_timer();
    bus(1'b1, `USC_ADDR_CONTROL, 8'h04);
    bus(1'b1, `USC_ADDR_STATUS, 8'h0f);
    pulse_timer();
    rdc("wrap", `USC_ADDR_STATUS, 8'h40);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h46);
    rdc("strobe ignored", `USC_ADDR_STATUS, 8'h40);
    chk("irq gated", {7'h0, irq}, 8'h00);
    gie <= 1'b1;
    @(negedge clk);
    chk("irq pending", {7'h0, irq}, 8'h01);
    bus(1'b1, `USC_ADDR_STATUS, 8'h4f);
    @(negedge clk);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    pulse_timer();
    @(negedge clk);
    chk("irq timer", {7'h0, irq}, 8'h01);
    rdc("buffer", `USC_ADDR_BUFFER, 8'h2f);
    @(negedge clk);
    chk("irq buffer read", {7'h0, irq}, 8'h00);
  endtask
  task automatic t_three();
    bus(1'b1, `USC_ADDR_PINS, 8'h20);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h10);
    bus(1'b1, `USC_ADDR_DATA, 8'h80);
    @(negedge clk);
    chk("three out", {5'h0, do_pu, do_oe, do_o}, 8'h03);
    bus(1'b1, `USC_ADDR_STATUS, 8'h00);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h11);
    rdc("toggle", `USC_ADDR_PINS, 8'h21);
    // A strobe acts under the clock source already stored, so the source is set first.
    bus(1'b1, `USC_ADDR_CONTROL, 8'h18);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h1a);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h1b);
    rdc("toggle count", `USC_ADDR_STATUS, 8'h01);
    rdc("toggle back", `USC_ADDR_PINS, 8'h20);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h00);
    @(negedge clk);
    chk("port out", {6'h0, do_oe, do_o}, 8'h02);
  endtask
  task automatic t_two();
    int n;
    n = 0;
    bus(1'b1, `USC_ADDR_DATA, 8'hff);
    bus(1'b1, `USC_ADDR_STATUS, 8'h00);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h28);
    bus(1'b1, `USC_ADDR_PINS, 8'h0f);
    @(negedge clk);
    chk("two pins", {4'h0, di_pu, ck_pu, di_oe, ck_oe}, 8'h00);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (busy && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (busy) fails++;
    repeat (4) @(posedge clk);
    rdc("rx byte", `USC_ADDR_DATA, 8'h96);
    rdc("rx count", `USC_ADDR_STATUS, 8'h40);
    bus(1'b1, `USC_ADDR_STATUS, 8'h4f);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h30);
    bus(1'b1, `USC_ADDR_CONTROL, 8'h32);
    @(negedge clk);
    chk("ovf hold", {6'h0, di_oe, ck_oe}, 8'h03);
    bus(1'b1, `USC_ADDR_STATUS, 8'h40);
    @(negedge clk);
    chk("ovf release", {7'h0, ck_oe}, 8'h00);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rdc("start flag", `USC_ADDR_STATUS, 8'h80);
    chk("start hold", {7'h0, ck_oe}, 8'h01);
    bus(1'b1, `USC_ADDR_STATUS, 8'h80);
    @(negedge clk);
    chk("start release", {7'h0, ck_oe}, 8'h00);
  endtask
  task automatic close_out();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_soft();
    t_timer();
    t_three();
    t_two();
    close_out();
  end
  initial begin
    #100000;
    fails++;
    close_out();
  end
endmodule // usc_serial_ctrl_tb_top
`default_nettype wire
